// file: core/wfc_regs.sv
// wfc_regs: serial-port options, sequencer control and indirect window
//           into the internal word store holding the waveform settings
// assumes: the I2C/SPI front end decodes frames into wfc_req_t on clk_in
//
// Function
// - Quick data-out is enabled only while option bit 2 is set, clear after reset.
// - The serial data output is driven only while option bit 0 is set, clear after reset.
// - Sequencer control bit 2 aborts the sequencer while set and resets to zero.
// - Sequencer control bit 1 starts the sequencer, resets to one, and acts only with bit 0.
// - Sequencer control bit 0 enables the sequencer, so the register resets to 0003h.
// - The low eight bits of the pointer register select the next indirect word.
// - Each read or write of the word register advances the pointer by one.
// - A word write stores at the pointer and a word read returns the word there.
// - The shape field picks triangle, sawtooth, inverse sawtooth or off, resetting to 000.
// - The code-step field sets 1, 2, 3, 4, 6, 8, 16 or 32 LSB per step, resetting to 111.
// - The time-step field sets 4 us up to 5127.92 us per step, 0000 invalid, reset Ah.
// - The upper code limit sits in bits 15-6 of location 21h and resets to 2E4h.
// - The lower code limit sits in bits 15-6 of location 22h and resets to 064h.
// - The generator runs only while the start bit is set and stops when it clears.
`include "wfc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module wfc_regs
    import wfc_pkg::*;
#(
    parameter int                AW          = 8,
    parameter logic [15:0][20:0] STEP_CYCLES = {
        21'(`WFC_TS15_NS / `WFC_CLK_NS),
        21'(`WFC_TS14_NS / `WFC_CLK_NS),
        21'(`WFC_TS13_NS / `WFC_CLK_NS),
        21'(`WFC_TS12_NS / `WFC_CLK_NS),
        21'(`WFC_TS11_NS / `WFC_CLK_NS),
        21'(`WFC_TS10_NS / `WFC_CLK_NS),
        21'(`WFC_TS9_NS / `WFC_CLK_NS),
        21'(`WFC_TS8_NS / `WFC_CLK_NS),
        21'(`WFC_TS7_NS / `WFC_CLK_NS),
        21'(`WFC_TS6_NS / `WFC_CLK_NS),
        21'(`WFC_TS5_NS / `WFC_CLK_NS),
        21'(`WFC_TS4_NS / `WFC_CLK_NS),
        21'(`WFC_TS3_NS / `WFC_CLK_NS),
        21'(`WFC_TS2_NS / `WFC_CLK_NS),
        21'(`WFC_TS1_NS / `WFC_CLK_NS),
        21'h0
    }
) (
    input  wire logic     clk_in,
    input  wire logic     srst_in,
    input  wire wfc_req_t req_in,
    input  wire logic     sdo_data_in,
    input  wire logic     sdo_req_in,
    output logic [15:0]   rd_data_out,
    output logic          rd_valid_out,
    output logic          timeout_en_out,
    output logic          quick_dataout_on_out,
    output logic          sdo_out,
    output logic          sdo_oe_out,
    output logic          sequencer_on_out,
    output logic          sequencer_run_out,
    output logic          sequencer_abort_out,
    output logic [9:0]    dac_code_out,
    output logic          gen_active_out
);

    localparam int DEPTH = 1 << AW;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [15:0]   iface_r;
    logic [15:0]   seq_r;
    logic [15:0]   start_r;
    logic [AW-1:0] ptr_r;
    logic [15:0]   setup_r;
    logic [15:0]   upper_r;
    logic [15:0]   lower_r;
    logic [15:0]   mem_r [0:DEPTH-1];
    logic          seq_run_r;
    logic          sdo_r;
    logic          sdo_oe_r;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    logic          hit_iface;
    logic          hit_seq;
    logic          hit_start;
    logic          hit_ptr;
    logic          hit_word;
    logic          wr_iface;
    logic          wr_seq;
    logic          wr_start;
    logic          wr_ptr;
    logic          wr_word;
    logic          word_access;
    logic          loc_setup;
    logic          loc_upper;
    logic          loc_lower;
    logic          loc_plain;
    logic [15:0]   word_rd;
    logic [15:0]   rd_mux;
    logic [AW-1:0] ptr_nxt;

    assign hit_iface   = req_in.addr == `WFC_OFS_IFACE;
    assign hit_seq     = req_in.addr == `WFC_OFS_SEQ;
    assign hit_start   = req_in.addr == `WFC_OFS_START;
    assign hit_ptr     = req_in.addr == `WFC_OFS_PTR;
    assign hit_word    = req_in.addr == `WFC_OFS_WORD;
    assign wr_iface    = req_in.wr && hit_iface;
    assign wr_seq      = req_in.wr && hit_seq;
    assign wr_start    = req_in.wr && hit_start;
    assign wr_ptr      = req_in.wr && hit_ptr;
    assign wr_word     = req_in.wr && hit_word;
    assign word_access = (req_in.wr || req_in.rd) && hit_word;

    // indirect locations with reset values live in flops, the rest in the array
    assign loc_setup = ptr_r == AW'(`WFC_LOC_SETUP);
    assign loc_upper = ptr_r == AW'(`WFC_LOC_UPPER);
    assign loc_lower = ptr_r == AW'(`WFC_LOC_LOWER);
    assign loc_plain = !(loc_setup || loc_upper || loc_lower);

    assign word_rd = loc_setup ? setup_r :
                     loc_upper ? upper_r :
                     loc_lower ? lower_r :
                     mem_r[ptr_r];

    assign rd_mux = hit_iface ? iface_r :
                    hit_seq   ? seq_r :
                    hit_start ? start_r :
                    hit_ptr   ? {{(16 - AW){1'b0}}, ptr_r} :
                    hit_word  ? word_rd :
                    16'h0000;

    assign ptr_nxt = wr_ptr      ? req_in.wdata[AW-1:0] :
                     word_access ? ptr_r + AW'(`WFC_PTR_STEP) :
                     ptr_r;

    // ----------------------------------------------------------------
    // direct registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            iface_r <= `WFC_RST_IFACE;
            seq_r   <= `WFC_RST_SEQ;
            start_r <= `WFC_RST_START;
            ptr_r   <= AW'(`WFC_RST_PTR);
        end else begin
            if (wr_iface) begin
                iface_r <= req_in.wdata & `WFC_MSK_IFACE;
            end
            if (wr_seq) begin
                seq_r <= req_in.wdata & `WFC_MSK_SEQ;
            end
            if (wr_start) begin
                start_r <= req_in.wdata & `WFC_MSK_START;
            end
            ptr_r <= ptr_nxt;
        end
    end

    // ----------------------------------------------------------------
    // indirect words
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            setup_r <= `WFC_RST_SETUP;
            upper_r <= `WFC_RST_UPPER;
            lower_r <= `WFC_RST_LOWER;
        end else if (wr_word) begin
            if (loc_setup) begin
                setup_r <= req_in.wdata;
            end
            if (loc_upper) begin
                upper_r <= req_in.wdata;
            end
            if (loc_lower) begin
                lower_r <= req_in.wdata;
            end
        end
    end

    // plain store: no reset, contents undefined until written
    always_ff @(posedge clk_in) begin
        if (wr_word && loc_plain) begin
            mem_r[ptr_r] <= req_in.wdata;
        end
    end

    // ----------------------------------------------------------------
    // read answer, one cycle after the request
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rd_data_out  <= `WFC_RST_WORD;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= req_in.rd;
            if (req_in.rd) begin
                rd_data_out <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // serial port options and sequencer state
    // ----------------------------------------------------------------
    assign timeout_en_out       = iface_r[`WFC_IF_TIMEOUT];
    assign quick_dataout_on_out = iface_r[`WFC_IF_QUICK];
    assign sequencer_on_out     = seq_r[`WFC_SEQ_ON];
    assign sequencer_abort_out  = seq_r[`WFC_SEQ_ABORT];
    assign sequencer_run_out    = seq_run_r;
    assign sdo_out              = sdo_r;
    assign sdo_oe_out           = sdo_oe_r;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            seq_run_r <= 1'b0;
            sdo_r     <= 1'b0;
            sdo_oe_r  <= 1'b0;
        end else begin
            seq_run_r <= seq_r[`WFC_SEQ_RUN] && seq_r[`WFC_SEQ_ON];
            sdo_r     <= sdo_data_in && iface_r[`WFC_IF_DRIVE];
            sdo_oe_r  <= sdo_req_in && iface_r[`WFC_IF_DRIVE];
        end
    end

    // ----------------------------------------------------------------
    // waveform generator
    // ----------------------------------------------------------------
    wfc_gen_cfg_t gen_cfg;
    logic         shape_ok;

    assign shape_ok = setup_r[`WFC_SHAPE_HI:`WFC_SHAPE_LO] == `WFC_SHAPE_TRI ||
                      setup_r[`WFC_SHAPE_HI:`WFC_SHAPE_LO] == `WFC_SHAPE_SAW ||
                      setup_r[`WFC_SHAPE_HI:`WFC_SHAPE_LO] == `WFC_SHAPE_INV;

    assign gen_cfg.run    = start_r[`WFC_START_BIT] && shape_ok;
    assign gen_cfg.shape  = setup_r[`WFC_SHAPE_HI:`WFC_SHAPE_LO];
    assign gen_cfg.step   = setup_r[`WFC_STEP_HI:`WFC_STEP_LO];
    assign gen_cfg.ts     = setup_r[`WFC_TS_HI:`WFC_TS_LO];
    assign gen_cfg.top    = upper_r[`WFC_LIM_HI:`WFC_LIM_LO];
    assign gen_cfg.bottom = lower_r[`WFC_LIM_HI:`WFC_LIM_LO];

    wfc_wave_gen #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_gen (
        .clk_in     (clk_in),
        .srst_in    (srst_in),
        .cfg_in     (gen_cfg),
        .code_out   (dac_code_out),
        .active_out (gen_active_out)
    );

endmodule : wfc_regs

`default_nettype wire

// file: core/wfc_consts.svh
// wfc_consts.svh: offsets, field positions, reset values and step times
// assumes: included by the waveform config register block and its generator
`ifndef WFC_CONSTS_SVH
`define WFC_CONSTS_SVH

// ----------------------------------------------------------------
// direct register offsets
// ----------------------------------------------------------------
`define WFC_OFS_START     8'h24
`define WFC_OFS_IFACE     8'h26
`define WFC_OFS_SEQ       8'h27
`define WFC_OFS_PTR       8'h2b
`define WFC_OFS_WORD      8'h2c

// ----------------------------------------------------------------
// indirect locations behind the pointer/word window
// ----------------------------------------------------------------
`define WFC_LOC_SETUP     8'h20
`define WFC_LOC_UPPER     8'h21
`define WFC_LOC_LOWER     8'h22

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define WFC_RST_SETUP     16'h007a
`define WFC_RST_UPPER     16'hb900
`define WFC_RST_LOWER     16'h1900
`define WFC_RST_SEQ       16'h0003
`define WFC_RST_IFACE     16'h0000
`define WFC_RST_START     16'h0000
`define WFC_RST_PTR       8'h00
`define WFC_RST_WORD      16'h0000
`define WFC_MSK_IFACE     16'h1005
`define WFC_MSK_SEQ       16'h0007
`define WFC_MSK_START     16'h0001
`define WFC_PTR_STEP      8'h01

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WFC_IF_TIMEOUT    12
`define WFC_IF_QUICK      2
`define WFC_IF_DRIVE      0
`define WFC_SEQ_ABORT     2
`define WFC_SEQ_RUN       1
`define WFC_SEQ_ON        0
`define WFC_START_BIT     0
`define WFC_SHAPE_HI      10
`define WFC_SHAPE_LO      8
`define WFC_STEP_HI       6
`define WFC_STEP_LO       4
`define WFC_TS_HI         3
`define WFC_TS_LO         0
`define WFC_LIM_HI        15
`define WFC_LIM_LO        6

// ----------------------------------------------------------------
// waveform shape codes
// ----------------------------------------------------------------
`define WFC_SHAPE_TRI     3'h0
`define WFC_SHAPE_SAW     3'h1
`define WFC_SHAPE_INV     3'h2
`define WFC_SHAPE_OFF     3'h7

// ----------------------------------------------------------------
// step interval per time-step code, in ns, and clock period
// ----------------------------------------------------------------
`define WFC_CLK_NS        5
`define WFC_TS1_NS        4000
`define WFC_TS2_NS        8000
`define WFC_TS3_NS        12000
`define WFC_TS4_NS        18000
`define WFC_TS5_NS        27040
`define WFC_TS6_NS        40480
`define WFC_TS7_NS        60720
`define WFC_TS8_NS        91120
`define WFC_TS9_NS        136720
`define WFC_TS10_NS       205120
`define WFC_TS11_NS       418640
`define WFC_TS12_NS       575600
`define WFC_TS13_NS       732560
`define WFC_TS14_NS       2563920
`define WFC_TS15_NS       5127920

`endif

// file: core/wfc_pkg.sv
// wfc_pkg: types shared by the waveform config register block
// assumes: wfc_consts.svh holds every number
package wfc_pkg;

    // register request from the serial front end, same clock
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } wfc_req_t;

    // settings handed to the waveform generator
    typedef struct packed {
        logic        run;
        logic [2:0]  shape;
        logic [2:0]  step;
        logic [3:0]  ts;
        logic [9:0]  top;
        logic [9:0]  bottom;
    } wfc_gen_cfg_t;

    typedef enum logic [1:0] {
        WFC_IDLE,
        WFC_RISE,
        WFC_FALL
    } wfc_gen_state_t;

endpackage : wfc_pkg

// file: core/wfc_wave_gen.sv
// wfc_wave_gen: stepping DAC code generator, triangle and sawtooth shapes
// assumes: cfg_in from registers on the same clock
`include "wfc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module wfc_wave_gen
    import wfc_pkg::*;
#(
    parameter logic [15:0][20:0] STEP_CYCLES = '0
) (
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    input  wire wfc_gen_cfg_t cfg_in,
    output logic [9:0]        code_out,
    output logic              active_out
);

    wfc_gen_state_t state_r;
    wfc_gen_state_t state_nxt;
    logic [9:0]     code_nxt;
    logic [20:0]    timer_r;
    logic [9:0]     step_amt;
    logic [20:0]    period;
    logic           tick;
    logic [10:0]    up_sum;
    logic           up_hit;
    logic           dn_hit;
    logic           wrap;

    // ----------------------------------------------------------------
    // step size and interval decode
    // ----------------------------------------------------------------
    assign step_amt = (cfg_in.step == 3'h4) ? 10'h006 :
                      (cfg_in.step == 3'h5) ? 10'h008 :
                      (cfg_in.step == 3'h6) ? 10'h010 :
                      (cfg_in.step == 3'h7) ? 10'h020 :
                      10'({cfg_in.step[1:0]} + 3'h1);
    assign period   = STEP_CYCLES[cfg_in.ts];
    assign tick     = (state_r != WFC_IDLE) && (period != 21'h0) &&
                      (timer_r >= period - 21'h1);
    assign up_sum   = {1'b0, code_out} + {1'b0, step_amt};
    assign up_hit   = up_sum >= {1'b0, cfg_in.top};
    // landing exactly on the lower limit turns at once, mirroring the upper limit
    assign dn_hit   = {1'b0, code_out} <= ({1'b0, cfg_in.bottom} + {1'b0, step_amt});
    assign wrap     = cfg_in.shape != `WFC_SHAPE_TRI;

    // ----------------------------------------------------------------
    // shape state machine
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        code_nxt  = code_out;
        case (state_r)
            WFC_IDLE: begin
                if (cfg_in.run) begin
                    if (cfg_in.shape == `WFC_SHAPE_INV) begin
                        state_nxt = WFC_FALL;
                        code_nxt  = cfg_in.top;
                    end else begin
                        state_nxt = WFC_RISE;
                        code_nxt  = cfg_in.bottom;
                    end
                end
            end
            WFC_RISE: begin
                if (tick) begin
                    if (!up_hit) begin
                        code_nxt = up_sum[9:0];
                    end else if (wrap) begin
                        code_nxt = cfg_in.bottom;
                    end else begin
                        code_nxt  = cfg_in.top;
                        state_nxt = WFC_FALL;
                    end
                end
            end
            WFC_FALL: begin
                if (tick) begin
                    if (!dn_hit) begin
                        code_nxt = code_out - step_amt;
                    end else if (wrap) begin
                        code_nxt = cfg_in.top;
                    end else begin
                        code_nxt  = cfg_in.bottom;
                        state_nxt = WFC_RISE;
                    end
                end
            end
            default: begin
                state_nxt = WFC_IDLE;
            end
        endcase
        if (!cfg_in.run) begin
            state_nxt = WFC_IDLE;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_r    <= WFC_IDLE;
            code_out   <= 10'h000;
            timer_r    <= 21'h0;
            active_out <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            code_out   <= code_nxt;
            timer_r    <= (tick || state_r == WFC_IDLE) ? 21'h0 : timer_r + 21'h1;
            active_out <= state_nxt != WFC_IDLE;
        end
    end

endmodule : wfc_wave_gen

`default_nettype wire

// file: sim/wfc_regs_monitor.sv
// wfc_regs_monitor: port assertions for the register block
// assumes: bound into wfc_regs, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module wfc_regs_monitor
    import wfc_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        srst_in,
    input wire wfc_req_t    req_in,
    input wire logic        sdo_data_in,
    input wire logic        sdo_req_in,
    input wire logic [15:0] rd_data_out,
    input wire logic        rd_valid_out,
    input wire logic        timeout_en_out,
    input wire logic        quick_dataout_on_out,
    input wire logic        sdo_out,
    input wire logic        sdo_oe_out,
    input wire logic        sequencer_on_out,
    input wire logic        sequencer_run_out,
    input wire logic        sequencer_abort_out,
    input wire logic [9:0]  dac_code_out,
    input wire logic        gen_active_out
);
// --
// option mirror
// --
logic [15:0] opt_r;
logic [15:0] opt_nxt;
wire         opt_wr = req_in.wr && req_in.addr == 8'h26;
wire         seq_wr = req_in.wr && req_in.addr == 8'h27;
assign opt_nxt = srst_in ? 16'h0000 : opt_wr ? req_in.wdata & 16'h1005 : opt_r;
always_ff @(posedge clk_in) opt_r <= opt_nxt;
// --
// assertions
// --
default clocking mon_cb @(posedge clk_in); endclocking
default disable iff (srst_in);
sequence bits_s;
    sequencer_on_out == $past(req_in.wdata[0]) && sequencer_abort_out == $past(req_in.wdata[2]);
endsequence
sequence run_s;
    sequencer_run_out == $past(req_in.wdata[1] & req_in.wdata[0], 2);
endsequence
rd_answer_a: assert property (req_in.rd |=> rd_valid_out)
    else $error("read not answered");
rd_only_a: assert property (rd_valid_out |-> $past(req_in.rd))
    else $error("answer without read");
rd_hold_a: assert property (!rd_valid_out && !$past(srst_in) |-> $stable(rd_data_out))
    else $error("read data moved");
opt_pins_a: assert property (timeout_en_out == opt_r[12] && quick_dataout_on_out == opt_r[2])
    else $error("option pins wrong");
sdo_gate_a: assert property (!$past(srst_in) |-> sdo_oe_out == $past(sdo_req_in & opt_r[0])
    && sdo_out == $past(sdo_data_in & opt_r[0]))
    else $error("data out gate wrong");
seq_write_a: assert property (seq_wr |=> bits_s ##1 run_s)
    else $error("sequencer bits wrong");
run_on_a: assert property (sequencer_run_out |-> $past(sequencer_on_out))
    else $error("run without enable");
code_hold_a: assert property (!gen_active_out && !$past(gen_active_out) && !$past(srst_in)
    |-> $stable(dac_code_out))
    else $error("code moved while idle");
endmodule : wfc_regs_monitor
bind wfc_regs wfc_regs_monitor mon (.clk_in(clk_in), .srst_in(srst_in), .req_in(req_in),
    .sdo_data_in(sdo_data_in), .sdo_req_in(sdo_req_in), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .timeout_en_out(timeout_en_out),
    .quick_dataout_on_out(quick_dataout_on_out), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
    .sequencer_on_out(sequencer_on_out), .sequencer_run_out(sequencer_run_out),
    .sequencer_abort_out(sequencer_abort_out), .dac_code_out(dac_code_out),
    .gen_active_out(gen_active_out));
`default_nettype wire

// file: sim/wfc_host.sv
// wfc_host: host controller model issuing register requests
// assumes: one request per call, launched on a falling edge
`timescale 1ns/1ps
`default_nettype none
module wfc_host
    import wfc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic [15:0] rd_data_in,
    input  wire logic        rd_valid_in,
    output var  wfc_req_t    req_out
);
// --
// request tasks
// --
initial req_out = '0;
task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_in);
    req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_in);
    req_out <= '0;
endtask : wr
// answer awaited a few cycles at most, else unknown
task automatic rd(input logic [7:0] a, output logic [15:0] d);
    d = 16'hxxxx;
    @(negedge clk_in);
    req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge clk_in);
    req_out <= '0;
    for (int i = 0; i < 4; i++) begin
        if (rd_valid_in === 1'b1) begin
            d = rd_data_in;
            break;
        end
        @(negedge clk_in);
    end
endtask : rd
endmodule : wfc_host
`default_nettype wire

// file: sim/testbench.sv
// testbench: host model drives wfc_regs, outputs checked against models
// assumes: checker bound to uut, inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module testbench
    import wfc_pkg::*;
;
// --
// models
// --
function automatic logic [15:0][20:0] mk_steps();
    for (int i = 1; i < 16; i++)
        mk_steps[i] = 21'(3 * i + 2);
    mk_steps[0] = '0;
endfunction : mk_steps
localparam logic [15:0][20:0] STEPS = mk_steps();
localparam int STEPV [8] = '{1, 2, 3, 4, 6, 8, 16, 32};
function automatic int nxt(input logic [2:0] sh, input int c, s, lo, hi, inout logic up);
    int r = up ? (c + s >= hi ? hi : c + s) : (c <= lo + s ? lo : c - s);
    if (sh == 3'h1)
        return c + s >= hi ? lo : c + s;
    if (sh == 3'h2)
        return c <= lo + s ? hi : c - s;
    up = up ? r != hi : r == lo;
    return r;
endfunction : nxt
logic        clk_in;
logic        srst_in;
logic        sdo_data = 1'b0;
logic        sdo_req = 1'b0;
logic        rd_valid, tmo, quick, sdo, sdo_oe, sq_on, sq_run, sq_abort, active;
logic [15:0] rd_data;
logic [9:0]  code;
wfc_req_t    req;
int          seed = 10354;
int          seed2 = 10354;
int          bad_count = 0;
int          check_count = 0;
wfc_host host (.clk_in(clk_in), .rd_data_in(rd_data), .rd_valid_in(rd_valid), .req_out(req));
wfc_regs #(.STEP_CYCLES(STEPS)) uut (.clk_in(clk_in), .srst_in(srst_in), .req_in(req),
    .sdo_data_in(sdo_data), .sdo_req_in(sdo_req), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .timeout_en_out(tmo), .quick_dataout_on_out(quick),
    .sdo_out(sdo), .sdo_oe_out(sdo_oe), .sequencer_on_out(sq_on),
    .sequencer_run_out(sq_run), .sequencer_abort_out(sq_abort),
    .dac_code_out(code), .gen_active_out(active));
initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
end
always @(negedge clk_in) begin
    sdo_data <= 1'($random(seed2));
    sdo_req <= 1'($random(seed2));
end
// --
// checks
// --
task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
        bad_count++;
        $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
endtask : chk
task automatic rdc(input logic [7:0] a, input logic [15:0] exp, input string m);
    logic [15:0] d;
    host.rd(a, d);
    chk(d, exp, m);
endtask : rdc
task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask : end_sim
// --
// scenarios
// --
initial begin
    logic [15:0] v;
    logic [15:0] w [3];
    logic [7:0]  p;
    logic [2:0]  sh, st;
    logic [3:0]  ts;
    logic        up;
    int          lo, hi, c0, e, cnt;
    srst_in = 1'b1;
    repeat (8) @(negedge clk_in);
    srst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk(16'({tmo, quick, sdo_oe, sq_on, sq_run, sq_abort, active}), 16'h000c, "pins");
    rdc(8'h26, 16'h0000, "opt");
    rdc(8'h27, 16'h0003, "seq");
    rdc(8'h20, 16'h0000, "unmapped");
    host.wr(8'h2b, 16'hff20);
    rdc(8'h2c, 16'h007a, "setup");
    rdc(8'h2c, 16'hb900, "upper");
    rdc(8'h2c, 16'h1900, "lower");
    rdc(8'h2b, 16'h0023, "ptr");
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
        v = k == 0 ? 16'hffff : k == 1 ? 16'h0000 : 16'($random(seed));
        host.wr(8'h26, v);
        chk(16'({tmo, quick}), 16'({v[12], v[2]}), "opt pins");
        @(negedge clk_in);
        chk(16'({sdo_oe, sdo}), 16'({sdo_req & v[0], sdo_data & v[0]}), "sdo");
        rdc(8'h26, v & 16'h1005, "opt rd");
    end
    for (int k = 0; k < 8; k++) begin
        v = {13'($random(seed)), 3'(k)};
        host.wr(8'h27, v);
        @(negedge clk_in);
        chk(16'({sq_abort, sq_run, sq_on}), 16'({v[2], v[1] & v[0], v[0]}), "seq");
        rdc(8'h27, v & 16'h0007, "seq rd");
    end
    host.wr(8'h27, 16'h0003);
    $display("test options done");
    for (int j = 0; j < 2; j++) begin
        p = j == 0 ? 8'hfe : 8'($random(seed));
        host.wr(8'h2b, 16'(p));
        foreach (w[i]) begin
            w[i] = 16'($random(seed));
            host.wr(8'h2c, w[i]);
        end
        host.wr(8'h2b, {8'($random(seed)), p});
        foreach (w[i]) rdc(8'h2c, w[i], "word");
        rdc(8'h2b, {8'h00, 8'(p + 8'h03)}, "ptr wrap");
    end
    $display("test window done");
    for (int i = 0; i < 4; i++) begin
        sh = i == 0 ? 3'h7 : 3'(i - 1);
        st = 3'($random(seed));
        ts = 4'(1 + {$random(seed)} % 3);
        lo = {$random(seed)} % 128;
        hi = lo + 100 + {$random(seed)} % 128;
        host.wr(8'h24, 16'h0000);
        repeat (3) @(negedge clk_in);
        c0 = code;
        chk(16'(active), 16'h0000, "stop");
        host.wr(8'h2b, 16'h0020);
        host.wr(8'h2c, {5'h00, sh, 1'b0, st, ts});
        host.wr(8'h2c, {10'(hi), 6'h3f});
        host.wr(8'h2c, {10'(lo), 6'h15});
        chk(16'(code), 16'(c0), "held");
        host.wr(8'h24, 16'h0001);
        for (cnt = 0; active !== 1'b1 && cnt < 8; cnt++)
            @(negedge clk_in);
        chk(16'(active), 16'(sh != 3'h7), "start");
        e = sh == 3'h2 ? hi : lo;
        up = 1'b1;
        for (int k = 0; k < 16 && sh != 3'h7; k++) begin
            chk(16'(code), 16'(e), "code");
            c0 = code;
            e = nxt(sh, c0, STEPV[st], lo, hi, up);
            for (cnt = 0; code === 10'(c0) && cnt < 40; cnt++)
                @(negedge clk_in);
            chk(16'(cnt), 16'(STEPS[ts]), "step time");
            if (cnt == 40)
                end_sim();
        end
        $display("test shape %0d done", sh);
    end
    srst_in = 1'b1;
    @(negedge clk_in);
    srst_in = 1'b0;
    @(negedge clk_in);
    chk(16'({active, code}), 16'h0000, "rerun");
    rdc(8'h27, 16'h0003, "rerun seq");
    $display("test rerun done");
    end_sim();
end
endmodule : testbench
`default_nettype wire
